/* File: hw/wdt_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define OFS_BT_MODE 5'h00
`define OFS_BT_COUNT 5'h04
`define OFS_WD_MODE 5'h08
`define OFS_WD_CLEAR 5'h0C
`define OFS_IRQ_STATUS 5'h10
`define OFS_IRQ_MASK 5'h14
`define OFS_CTRL 5'h18
`define BIT_RESTART 3
`define BIT_WD_CLEAR 3
`define BT_MODE_RESET 4'h0
`define WD_MODE_RESET 8'hA5
`define WD_DISABLE_KEY 8'h5A
`define SEL_DIV12 3'h0
`define SEL_DIV9 3'h3
`define SEL_DIV7 3'h5
`define SEL_DIV5 3'h7
`define PRE_W 12
`define STAT_BIT_INTERVAL 0
`define STAT_BIT_WD 1
`define STAB_MS 31.3
`define STAB_FXX_MHZ 4.19
// Stabilisation wait: 31.3 ms at 4.19 MHz equals 2^17 system clocks
`define STAB_CYCLES 32'd131072
`endif

/* File: hw/wdt_pkg.sv */
// Types shared by the interval timer and watchdog
package wdt_pkg;
    typedef struct packed {
        logic overflow;
        logic wd_reset;
    } timer_events_t;
    typedef enum logic [1:0] {
        ST_STAB,
        ST_RUN
    } run_state_t;
endpackage : wdt_pkg

/* File: hw/prescaler.sv */
// Prescaler that turns the mode selection into a count-clock tick
`timescale 1ns/1ps
`include "wdt_consts.svh"
module prescaler #(
    parameter int PRE_W = `PRE_W
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic restart,
    input wire logic [2:0] sel,
    // Tick
    output logic tick
);
    logic [PRE_W-1:0] div_r;

    function automatic int sel_shift(input logic [2:0] s);
        case (s)
            `SEL_DIV9: sel_shift = 9;
            `SEL_DIV7: sel_shift = 7;
            `SEL_DIV5: sel_shift = 5;
            default: sel_shift = 12;
        endcase
    endfunction : sel_shift

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // A tick when the low bits for the selected rate wrap; rate changes apply at once
    always_comb begin
        logic [PRE_W-1:0] m;
        m = '0;
        m = (PRE_W'(1) << sel_shift(sel)) - PRE_W'(1);
        tick = ((div_r & m) == m);
    end
endmodule : prescaler

/* File: hw/interval_watchdog.sv */
// Interval timer with watchdog and stabilisation hold, AXI4-Lite slave
`timescale 1ns/1ps
`include "wdt_consts.svh"
module interval_watchdog
    import wdt_pkg::*;
#(
    parameter int STAB_CYCLES = `STAB_CYCLES,
    parameter int PRE_W = `PRE_W
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power-down state and service
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic stop_release,
    input wire logic irq_ack,
    // System outputs
    output logic irq,
    output logic sys_reset_req,
    output logic cpu_hold
);
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    logic [3:0] bt_mode_r;
    logic [7:0] bt_count_r;
    logic [7:0] wd_mode_r;
    logic [2:0] wd_count_r;
    logic irq_flag_r;
    logic irq_enable_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic sys_reset_r;
    logic hold_r;
    logic [31:0] stab_cnt_r;
    logic stop_wait_r;
    logic [7:0] wait_cnt_r;
    run_state_t state_r;

    logic aw_held_r;
    logic w_held_r;
    logic [4:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic tick;
    logic wr_go;
    logic restart;
    logic wd_clear;
    logic wd_enabled;
    timer_events_t ev;

    function automatic logic mapped(input logic [4:0] a);
        case (a)
            `OFS_BT_MODE, `OFS_BT_COUNT, `OFS_WD_MODE, `OFS_WD_CLEAR,
            `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_CTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Write channel: address and data captured independently, in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 5'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Only the low byte carries register data; writes need lane 0
    assign restart = wr_go && wstrb_r[0] && hit(awaddr_r, `OFS_BT_MODE)
        && wdata_r[`BIT_RESTART];
    assign wd_clear = wr_go && wstrb_r[0] && hit(awaddr_r, `OFS_WD_CLEAR)
        && wdata_r[`BIT_WD_CLEAR];

    // Restart bit is never stored, so it reads back as zero and acts as self-clearing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bt_mode_r <= `BT_MODE_RESET;
        end else if (wr_go && wstrb_r[0] && hit(awaddr_r, `OFS_BT_MODE)) begin
            bt_mode_r <= {1'b0, wdata_r[2:0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_mode_r <= `WD_MODE_RESET;
        end else if (wr_go && wstrb_r[0] && hit(awaddr_r, `OFS_WD_MODE)) begin
            wd_mode_r <= wdata_r[7:0];
        end
    end
    assign wd_enabled = (wd_mode_r != `WD_DISABLE_KEY);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_r <= 1'b0;
            mask_r <= 2'b00;
        end else if (wr_go && wstrb_r[0]) begin
            if (hit(awaddr_r, `OFS_CTRL)) begin
                irq_enable_r <= wdata_r[0];
            end
            if (hit(awaddr_r, `OFS_IRQ_MASK)) begin
                mask_r <= wdata_r[1:0];
            end
        end
    end

    prescaler #(
        .PRE_W(PRE_W)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(restart),
        .sel(bt_mode_r[2:0]),
        .tick(tick)
    );

    // Counter runs until a restart write clears it; reset clears it too, a defined value is harmless
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            bt_count_r <= 8'h00;
        end else if (tick) begin
            bt_count_r <= bt_count_r + 8'h01;
        end
    end
    assign ev.overflow = tick && (bt_count_r == 8'hFF);

    // Restart wins over set; set wins over the status-write and acknowledge clears
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            irq_flag_r <= 1'b0;
        end else if (ev.overflow) begin
            irq_flag_r <= 1'b1;
        end else if (irq_ack || (wr_go && wstrb_r[0] && hit(awaddr_r, `OFS_IRQ_STATUS)
                && wdata_r[`STAT_BIT_INTERVAL])) begin
            irq_flag_r <= 1'b0;
        end
    end

    // Overflow-driven watchdog: eight wraps of the interval counter
    always_ff @(posedge aclk) begin
        if (!aresetn || stop_mode || wait_mode || wd_clear) begin
            wd_count_r <= 3'h0;
        end else if (ev.overflow) begin
            wd_count_r <= wd_count_r + 3'h1;
        end
    end
    assign ev.wd_reset = ev.overflow && (wd_count_r == 3'h7) && wd_enabled
        && !stop_mode && !wait_mode && !wd_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset_r <= 1'b0;
        end else begin
            sys_reset_r <= ev.wd_reset;
        end
    end
    assign sys_reset_req = sys_reset_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 2'b00;
        end else begin
            status_r <= (status_r & ~(wr_go && wstrb_r[0] && hit(awaddr_r, `OFS_IRQ_STATUS)
                ? wdata_r[1:0] : 2'b00)) | {ev.wd_reset, ev.overflow};
        end
    end
    assign irq = (|(status_r & mask_r)) || (irq_flag_r && irq_enable_r);

    // Power-on hold, then stop-release hold of 256 ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_STAB;
            stab_cnt_r <= 32'h0000_0000;
            hold_r <= 1'b1;
        end else begin
            case (state_r)
                ST_STAB: begin
                    if (stab_cnt_r >= 32'(STAB_CYCLES - 1)) begin
                        state_r <= ST_RUN;
                        hold_r <= 1'b0;
                    end else begin
                        stab_cnt_r <= stab_cnt_r + 32'h0000_0001;
                    end
                end
                ST_RUN: begin
                    hold_r <= stop_wait_r || stop_release;
                end
                default: begin
                    state_r <= ST_STAB;
                end
            endcase
        end
    end
    assign cpu_hold = hold_r;

    // Wait time counts 256 ticks of the selected rate, as the interval does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_wait_r <= 1'b0;
            wait_cnt_r <= 8'h00;
        end else if (stop_release) begin
            stop_wait_r <= 1'b1;
            wait_cnt_r <= 8'h00;
        end else if (stop_wait_r && tick) begin
            wait_cnt_r <= wait_cnt_r + 8'h01;
            if (wait_cnt_r == 8'hFF) begin
                stop_wait_r <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after acceptance
    assign s_axi_arready = !rvalid_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                `OFS_BT_COUNT: rdata_r <= {24'h000000, bt_count_r};
                `OFS_IRQ_STATUS: rdata_r <= {30'h00000000, status_r};
                `OFS_IRQ_MASK: rdata_r <= {30'h00000000, mask_r};
                `OFS_CTRL: rdata_r <= {28'h0000000, wd_count_r, irq_flag_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule : interval_watchdog

/* File: bench/interval_watchdog_assertions.sv */
// Port checker for the interval timer and watchdog
`timescale 1ns/1ps
module interval_watchdog_assertions #(
    parameter int STAB_CYCLES = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // System outputs
    input wire logic sys_reset_req,
    input wire logic cpu_hold
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Edges since reset release, for the stabilisation window
    int unsigned up_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) up_cnt_r <= 0;
        else up_cnt_r <= up_cnt_r + 1;
    end
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
    a_read_unmapped: assert property (ar_taken and s_axi_araddr == 5'h1C
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    a_hold_start: assert property (disable iff (1'b0) !aresetn |=> cpu_hold)
        else $error("hold missing after reset");
    a_hold_window: assert property (up_cnt_r < STAB_CYCLES - 1 |-> cpu_hold)
        else $error("hold ended early");
    a_hold_ends: assert property (up_cnt_r == STAB_CYCLES + 1 |-> !cpu_hold)
        else $error("hold ended late");
endmodule : interval_watchdog_assertions
bind interval_watchdog interval_watchdog_assertions #(.STAB_CYCLES(STAB_CYCLES)) chk (.*);

/* File: bench/interval_watchdog_tb.sv */
// Self-checking bench for the interval timer and watchdog
`timescale 1ns/1ps
module interval_watchdog_tb;
    localparam int STAB = 16;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic stop_mode = 1'b0, wait_mode = 1'b0, stop_release = 1'b0, irq_ack = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic irq, sys_reset_req, cpu_hold;
    logic [2:0] sels [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
    int divs [4] = '{4096, 512, 128, 32};
    int n_errors = 0, cmp_count = 0, seed = 66915, k, t;
    interval_watchdog #(.STAB_CYCLES(STAB)) DUT (.*);
    always #25 aclk = ~aclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    function automatic logic [31:0] near(input logic [31:0] s, input int e, input int tol);
        return (s + 32'(tol) >= 32'(e) && s <= 32'(e + tol)) ? 32'h1 : 32'h0;
    endfunction : near
    // Handshakes are judged at the falling edge, where ready and valid are settled
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        logic done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (done !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [4:0] a);
        logic ar_ok;
        logic done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (done !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rdr
    // Counter may tick between reads, so take it only when two reads agree
    task automatic rd_count;
        logic [31:0] first;
        do begin
            rdr(5'h04);
            first = rd;
            rdr(5'h04);
        end while (first !== rd);
    endtask : rd_count
    task automatic chk_irq(input logic exp);
        @(negedge aclk);
        check(irq, exp);
    endtask : chk_irq
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(cpu_hold, 1'b1);
        repeat (STAB + 2) @(negedge aclk);
        check(cpu_hold, 1'b0);
        rdr(5'h1C);
        check(rsp, 2'h2);
        check(rd, 32'h0);
        wr(5'h1C, 32'h1);
        check(rsp, 2'h2);
        rdr(5'h08);
        check(rd, 32'h0);
        wr(5'h00, 32'h0000000F);
        @(posedge aclk) stop_release <= 1'b1;
        @(posedge aclk) stop_release <= 1'b0;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
        end while (cpu_hold !== 1'b0 && t < 20000);
        check(near(t, 256 * 32, 40), 32'h1);
        repeat (100) @(posedge aclk);
        rdr(5'h10);
        check(rd[0], 1'b1);
        rdr(5'h18);
        check(rd[3:1], 3'h1);
        wr(5'h14, 32'h0);
        chk_irq(1'b0);
        wr(5'h14, 32'h1);
        chk_irq(1'b1);
        // Enable the flag path, then mask the status path off
        wr(5'h18, 32'h1);
        wr(5'h14, 32'h0);
        chk_irq(1'b1);
        @(posedge aclk) irq_ack <= 1'b1;
        @(posedge aclk) irq_ack <= 1'b0;
        chk_irq(1'b0);
        wr(5'h10, 32'h1);
        rdr(5'h10);
        check(rd[0], 1'b0);
        @(posedge aclk) stop_mode <= 1'b1;
        @(posedge aclk) stop_mode <= 1'b0;
        rdr(5'h18);
        check(rd[3:1], 3'h0);
        for (int i = 0; i < 4; i++) begin
            k = 1 + ($unsigned($random(seed)) % 3);
            wr(5'h00, {28'h0, 1'b1, sels[i]});
            rdr(5'h18);
            check(rd[0], 1'b0);
            repeat (k * divs[i]) @(posedge aclk);
            rd_count;
            check(near(rd, k, 1), 32'h1);
        end
        // Odd value can never equal the disable key
        wr(5'h08, {24'h0, 8'($random(seed)) | 8'h01});
        wr(5'h00, 32'h0000000F);
        wr(5'h0C, 32'h00000008);
        @(posedge aclk) wait_mode <= 1'b1;
        @(posedge aclk) wait_mode <= 1'b0;
        rdr(5'h18);
        check(rd[3:1], 3'h0);
        t = 0;
        do begin
            @(posedge aclk);
            t++;
        end while (sys_reset_req !== 1'b1 && t < 70000);
        check(near(t, 8 * 256 * 32, 64), 32'h1);
        rdr(5'h10);
        check(rd[1], 1'b1);
        stop_test;
    end
    initial begin
        repeat (99000) @(posedge aclk);
        n_errors++;
        stop_test;
    end
endmodule : interval_watchdog_tb
